/* File: include/mms_pkg.sv */
/*
 Shared constants and types for the meter measurement settings block:
 levels, edit states, parameter indices, timing counts and the key carrier.
 Assumes a 20 MHz system clock.
*/
package mms_pkg;
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned TENTH_S_CYCLES  = CLK_HZ / 10;
    localparam int unsigned HOLD_LONG_S     = 3;
    localparam int unsigned HOLD_SHORT_S    = 1;
    localparam int unsigned HOLD_LONG_TENTHS  = HOLD_LONG_S * 10;
    localparam int unsigned HOLD_SHORT_TENTHS = HOLD_SHORT_S * 10;
    localparam int unsigned AUTOZERO_MAX_TENTHS = 199;
    localparam int unsigned STARTUP_MAX_TENTHS  = 999;
    localparam int unsigned HYST_MAX        = 9999;
    localparam logic [13:0] HYST_MIN        = 14'h0001;
    localparam logic [13:0] PASS_PROC_MAG   = 14'h00A9;
    localparam logic [13:0] PASS_TEMP_MAG   = 14'h00A9;
    // Averaging codes: 0 off, 1 two, 2 four, 3 eight
    localparam logic [1:0]  MEAN_OFF        = 2'h0;
    localparam logic [1:0]  MEAN_RST        = 2'h0;
    localparam logic [13:0] HYST_RST        = 14'h0000;
    localparam logic [7:0]  AUTOZERO_RST    = 8'h00;
    localparam logic [9:0]  STARTUP_RST     = 10'h000;
    // Parameter order of the advanced-function level
    localparam logic [2:0]  PAR_MEAN        = 3'h0;
    localparam logic [2:0]  PAR_HYS1        = 3'h1;
    localparam logic [2:0]  PAR_HYS2        = 3'h2;
    localparam logic [2:0]  PAR_AUTOZ       = 3'h3;
    localparam logic [2:0]  PAR_STARTUP     = 3'h4;
    localparam logic [2:0]  PAR_LAST        = 3'h4;

    typedef enum logic [1:0] {
        MMS_LVL_OPER = 2'h0,
        MMS_LVL_INIT = 2'h1,
        MMS_LVL_ADV  = 2'h3
    } mms_level_t;

    typedef enum logic [1:0] {
        MMS_ED_NAME  = 2'h0,
        MMS_ED_VALUE = 2'h1,
        MMS_ED_EDIT  = 2'h3
    } mms_edit_t;

    typedef struct packed {
        logic level;
        logic mode;
        logic shift;
        logic up;
    } mms_keys_t;
endpackage : mms_pkg

/* File: testbench/mms_operator.sv */
/*
 Operator at the front-panel keys and the password entry.
 Assumes keys are sampled on the rising edge of the system clock.
*/
module mms_operator (
    input  wire logic         clk_in,
    output mms_pkg::mms_keys_t keys_out,
    output logic              pass_sign_out,
    output logic [13:0]       pass_mag_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        keys_out = '0;
        pass_sign_out = 1'b0;
        pass_mag_out = 14'h0000;
    end
    // Bit 3 level, 2 mode, 1 shift, 0 up; a key is released between presses
    task automatic press(input int k, input int cycles);
        @(posedge clk_in);
        keys_out[k] <= 1'b1;
        repeat (cycles) @(posedge clk_in);
        keys_out[k] <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask : press
    task automatic enter_password(input logic [13:0] mag);
        @(posedge clk_in);
        pass_sign_out <= 1'b1;
        pass_mag_out <= mag;
        press(2, 1);
    endtask : enter_password
endmodule : mms_operator

/* File: testbench/mms_settings_props.sv */
/*
 Concurrent checks on the ports of the meter settings block.
 Assumes one clock domain and keys that are synchronous levels.
*/
module mms_settings_props #(
    parameter int W            = 16,
    parameter int TENTH_CYCLES = 10
) (
    input wire logic                clk_sys_in,
    input wire logic                nrst_in,
    input wire mms_pkg::mms_keys_t  keys_in,
    input wire logic                freq_mode_in,
    input wire logic                pulse_in,
    input wire logic [W-1:0]        setpoint1_in,
    input wire logic [W-1:0]        setpoint2_in,
    input wire mms_pkg::mms_level_t level_out,
    input wire mms_pkg::mms_edit_t  edit_state_out,
    input wire logic [2:0]          param_index_out,
    input wire logic                blink_out,
    input wire logic [13:0]         hyst1_out,
    input wire logic [13:0]         hyst2_out,
    input wire logic [7:0]          autozero_time_out,
    input wire logic                measuring_out,
    input wire logic [W-1:0]        readout_out,
    input wire logic                comp1_out,
    input wire logic                comp2_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Two ticks of margin cover the free-running timebase phase
    localparam int LONG_MIN  = (mms_pkg::HOLD_LONG_TENTHS - 2) * TENTH_CYCLES;
    localparam int SHORT_MIN = (mms_pkg::HOLD_SHORT_TENTHS - 2) * TENTH_CYCLES;
    logic [15:0] hold_cnt_reg;
    wire logic [W:0] eff1 = (W+1)'(hyst1_out == 14'h0000 ? 14'h0001 : hyst1_out);
    wire logic [W:0] eff2 = (W+1)'(hyst2_out == 14'h0000 ? 14'h0001 : hyst2_out);

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) hold_cnt_reg <= 16'h0000;
        else if (!keys_in.level) hold_cnt_reg <= 16'h0000;
        else if (hold_cnt_reg != 16'hFFFF) hold_cnt_reg <= hold_cnt_reg + 16'h0001;
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    chk_blink_edit: assert property (blink_out == (edit_state_out == mms_pkg::MMS_ED_EDIT))
        else $error("blink differs from edit state");
    chk_hyst_range: assert property (hyst1_out <= 14'h270F && hyst2_out <= 14'h270F)
        else $error("hysteresis above limit");
    chk_autoz_range: assert property (autozero_time_out <= 8'hC7)
        else $error("auto-zero time above limit");
    chk_comp1_set: assert property (measuring_out && readout_out >= setpoint1_in |=> comp1_out)
        else $error("output one not on at set value");
    chk_comp1_release: assert property (measuring_out && $stable(hyst1_out)
        && (W+1)'(readout_out) + eff1 <= (W+1)'(setpoint1_in) |=> !comp1_out)
        else $error("output one not off past band");
    chk_comp2_release: assert property (measuring_out && $stable(hyst2_out)
        && (W+1)'(readout_out) + eff2 <= (W+1)'(setpoint2_in) |=> !comp2_out)
        else $error("output two not off past band");
    chk_autozero_force: assert property ((freq_mode_in && !pulse_in && measuring_out
        && autozero_time_out == 8'h00) [*2] |=> readout_out == '0)
        else $error("readout not forced to zero");
    chk_long_hold: assert property (level_out == mms_pkg::MMS_LVL_INIT
        && $past(level_out) == mms_pkg::MMS_LVL_OPER |-> $past(hold_cnt_reg) >= LONG_MIN)
        else $error("initial level entered too early");
    chk_short_hold: assert property ((level_out == mms_pkg::MMS_LVL_OPER
        && $past(level_out) == mms_pkg::MMS_LVL_INIT) || (level_out == mms_pkg::MMS_LVL_INIT
        && $past(level_out) == mms_pkg::MMS_LVL_ADV) |-> $past(hold_cnt_reg) >= SHORT_MIN)
        else $error("level moved up too early");
    chk_edit_order: assert property ($past(edit_state_out) == mms_pkg::MMS_ED_NAME
        |-> edit_state_out != mms_pkg::MMS_ED_EDIT)
        else $error("edit entered from name state");
    chk_mode_commit: assert property ($rose(keys_in.mode) && level_out == mms_pkg::MMS_LVL_ADV
        && edit_state_out == mms_pkg::MMS_ED_EDIT |=> edit_state_out == mms_pkg::MMS_ED_NAME
        && param_index_out == ($past(param_index_out) == mms_pkg::PAR_LAST ? 3'h0
        : $past(param_index_out) + 3'h1))
        else $error("mode did not advance parameter");

    cov_adv: cover property (level_out == mms_pkg::MMS_LVL_ADV);
    cov_edit: cover property (edit_state_out == mms_pkg::MMS_ED_EDIT);
    cov_release: cover property ($fell(comp1_out));
endmodule : mms_settings_props

bind mms_settings mms_settings_props #(.W(W), .TENTH_CYCLES(TENTH_CYCLES)) props_i (.*);

/* File: testbench/test_meter_measurement_settings.sv */
/*
 Self-checking bench: key navigation, editing, comparators, averaging, auto-zero.
 Assumes a short tenth-second count so key holds stay brief.
*/
module test_meter_measurement_settings;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TC = 10;
    logic        clk_sys_in, nrst_in, freq_mode_in, sample_valid_in, pulse_in;
    logic [15:0] sample_in, setpoint1_in, setpoint2_in;
    mms_pkg::mms_keys_t  keys;
    mms_pkg::mms_level_t level;
    mms_pkg::mms_edit_t  edit;
    logic        pass_sign, blink, measuring, comp1, comp2;
    logic [13:0] pass_mag, hyst1, hyst2;
    logic [2:0]  param;
    logic [1:0]  mean_sel;
    logic [7:0]  autoz;
    logic [9:0]  startup;
    logic [15:0] readout;
    int          n_mismatch = 0;
    int          checked = 0;

    mms_operator op (.clk_in(clk_sys_in), .keys_out(keys), .pass_sign_out(pass_sign),
        .pass_mag_out(pass_mag));
    mms_settings #(.W(16), .TENTH_CYCLES(TC)) dut (.clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in), .keys_in(keys), .freq_mode_in(freq_mode_in),
        .sample_valid_in(sample_valid_in), .sample_in(sample_in), .pulse_in(pulse_in),
        .setpoint1_in(setpoint1_in), .setpoint2_in(setpoint2_in), .pass_sign_in(pass_sign),
        .pass_mag_in(pass_mag), .level_out(level), .edit_state_out(edit),
        .param_index_out(param), .blink_out(blink), .averaging_count_out(mean_sel),
        .hyst1_out(hyst1), .hyst2_out(hyst2), .autozero_time_out(autoz),
        .startup_delay_time_out(startup), .measuring_out(measuring), .readout_out(readout),
        .comp1_out(comp1), .comp2_out(comp2));

    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic stop_test;
        if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    task automatic sample(input logic [15:0] v);
        @(posedge clk_sys_in);
        sample_in <= v;
        sample_valid_in <= 1'b1;
        @(posedge clk_sys_in);
        sample_valid_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
    endtask : sample

    initial begin
        repeat (20000) @(posedge clk_sys_in);
        n_mismatch++;
        stop_test();
    end

    initial begin
        nrst_in = 1'b0;
        freq_mode_in = 1'b0;
        sample_valid_in = 1'b0;
        pulse_in = 1'b0;
        sample_in = 16'h0000;
        setpoint1_in = 16'h0064;
        setpoint2_in = 16'h0061;
        repeat (12) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        chk("measuring", 16'(measuring), 16'h0001);
        op.press(3, 5 * TC);
        chk("level short", 16'(level), 16'(mms_pkg::MMS_LVL_OPER));
        op.press(3, 32 * TC);
        chk("level init", 16'(level), 16'(mms_pkg::MMS_LVL_INIT));
        op.enter_password(14'h00A8);
        chk("level bad pass", 16'(level), 16'(mms_pkg::MMS_LVL_INIT));
        op.enter_password(mms_pkg::PASS_PROC_MAG);
        chk("level adv", 16'(level), 16'(mms_pkg::MMS_LVL_ADV));
        op.press(2, 1);
        chk("param", 16'(param), 16'(mms_pkg::PAR_HYS1));
        op.press(1, 1);
        chk("edit value", 16'(edit), 16'(mms_pkg::MMS_ED_VALUE));
        op.press(1, 1);
        chk("blink", 16'(blink), 16'h0001);
        repeat (5) op.press(0, 1);
        op.press(2, 1);
        chk("hyst1", 16'(hyst1), 16'h0005);
        chk("hyst2", 16'(hyst2), 16'h0000);
        chk("param next", 16'(param), 16'(mms_pkg::PAR_HYS2));
        chk("edit name", 16'(edit), 16'(mms_pkg::MMS_ED_NAME));
        sample(16'h0064);
        chk("comp1 on", 16'(comp1), 16'h0001);
        chk("comp2 on", 16'(comp2), 16'h0001);
        sample(16'h0060);
        chk("comp1 band", 16'(comp1), 16'h0001);
        chk("comp2 off", 16'(comp2), 16'h0000);
        sample(16'h005F);
        chk("comp1 off", 16'(comp1), 16'h0000);
        repeat (3) op.press(2, 1);
        chk("param wrap", 16'(param), 16'(mms_pkg::PAR_MEAN));
        // Codes 1 to 3 are committed in turn, then the order is walked back round
        for (int c = 1; c < 4; c++) begin
            op.press(1, 1);
            op.press(1, 1);
            op.press(0, 1);
            op.press(2, 1);
            chk("mean code", 16'(mean_sel), 16'(c));
            repeat (4) op.press(2, 1);
        end
        for (int i = 1; i < 9; i++) sample(16'(i * 8));
        chk("mean of eight", readout, 16'h0024);
        freq_mode_in <= 1'b1;
        sample(16'h0032);
        chk("auto zero", readout, 16'h0000);
        // Auto-zero time of two tenths: a pulse holds the readout off zero for a while
        repeat (3) op.press(2, 1);
        op.press(1, 1);
        op.press(1, 1);
        repeat (2) op.press(0, 1);
        op.press(2, 1);
        chk("autozero time", 16'(autoz), 16'h0002);
        pulse_in <= 1'b1;
        @(posedge clk_sys_in);
        pulse_in <= 1'b0;
        // Window now 80,50,64,56,48,40,32,24: mean 49 truncated
        sample(16'h0050);
        chk("az restart", readout, 16'h0031);
        repeat (30) @(posedge clk_sys_in);
        chk("az timeout", readout, 16'h0000);
        // Mode on a shown value moves on without saving it
        op.press(1, 1);
        op.press(2, 1);
        chk("startup kept", 16'(startup), 16'h0000);
        chk("param back", 16'(param), 16'(mms_pkg::PAR_MEAN));
        freq_mode_in <= 1'b0;
        op.press(3, 12 * TC);
        chk("level up", 16'(level), 16'(mms_pkg::MMS_LVL_INIT));
        op.press(3, 12 * TC);
        chk("level oper", 16'(level), 16'(mms_pkg::MMS_LVL_OPER));
        stop_test();
    end
endmodule : test_meter_measurement_settings

/* File: verilog/mms_compare.sv */
/*
 One comparative output with hysteresis, upper-limit action.
 Assumes the measured value and set value are in display digits.
*/
module mms_compare #(
    parameter int W = 16
) (
    input  wire logic         clk_sys_in,
    input  wire logic         nrst_in,
    input  wire logic         enable_in,
    input  wire logic [W-1:0] value_in,
    input  wire logic [W-1:0] setpoint_in,
    input  wire logic [13:0]  hyst_in,
    output logic              out_out
);
    logic          out_reg;
    logic [13:0]   hyst_eff;
    logic [W:0]    release_lvl;
    logic          out_next;

    assign hyst_eff    = (hyst_in == 14'h0000) ? mms_pkg::HYST_MIN : hyst_in;
    assign release_lvl = {1'b0, setpoint_in} - {{(W - 13){1'b0}}, hyst_eff};
    // Off once the value falls a full hysteresis below the set value, or falls below a set value smaller than the hysteresis
    assign out_next = !enable_in ? 1'b0 :
                      (value_in >= setpoint_in) ? 1'b1 :
                      (release_lvl[W] || ({1'b0, value_in} <= release_lvl)) ? 1'b0 :
                      out_reg;

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            out_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
        end
    end

    assign out_out = out_reg;
endmodule : mms_compare

/* File: verilog/mms_settings.sv */
/*
 Measurement settings and key navigation of a panel meter: averaging,
 hysteresis outputs, auto-zero, start-up delay and level/edit control.
 Assumes debounced synchronous keys and one-cycle sample and pulse strobes.
*/
module mms_settings #(
    parameter int W           = 16,
    parameter int TENTH_CYCLES = mms_pkg::TENTH_S_CYCLES,
    parameter bit TEMP_VARIANT = 1'b0
) (
    input  wire logic                clk_sys_in,
    input  wire logic                nrst_in,
    input  wire mms_pkg::mms_keys_t  keys_in,
    input  wire logic                freq_mode_in,
    input  wire logic                sample_valid_in,
    input  wire logic [W-1:0]        sample_in,
    input  wire logic                pulse_in,
    input  wire logic [W-1:0]        setpoint1_in,
    input  wire logic [W-1:0]        setpoint2_in,
    input  wire logic                pass_sign_in,
    input  wire logic [13:0]         pass_mag_in,
    output mms_pkg::mms_level_t      level_out,
    output mms_pkg::mms_edit_t       edit_state_out,
    output logic [2:0]               param_index_out,
    output logic                     blink_out,
    output logic [1:0]               averaging_count_out,
    output logic [13:0]              hyst1_out,
    output logic [13:0]              hyst2_out,
    output logic [7:0]               autozero_time_out,
    output logic [9:0]               startup_delay_time_out,
    output logic                     measuring_out,
    output logic [W-1:0]             readout_out,
    output logic                     comp1_out,
    output logic                     comp2_out
);
    mms_pkg::mms_level_t level_reg;
    mms_pkg::mms_edit_t  edit_reg;
    logic [2:0]          param_reg;
    logic [1:0]          mean_sel_reg;
    logic [13:0]         hyst1_reg, hyst2_reg, edit_val_reg;
    logic [7:0]          az_reg;
    logic [9:0]          st_reg;
    logic [31:0]         tick_cnt_reg;
    logic                tick;
    logic [4:0]          hold_reg;
    logic                hold_done_reg;
    logic                prev_shift_reg, prev_mode_reg, prev_up_reg;
    logic                shift_pulse, mode_pulse, up_pulse;
    logic [9:0]          start_cnt_reg;
    logic                measuring_reg;
    logic [7:0]          az_cnt_reg;
    logic                az_zero_reg;
    logic [W-1:0]        hist_reg [8];
    logic [W+2:0]        sum2, sum4, sum8;
    logic [W-1:0]        mean_val;
    logic [W-1:0]        readout_reg;
    logic [13:0]         edit_max;
    logic [13:0]         cur_val;
    logic                pass_ok;
    logic                hold_long, hold_short;

    // Tenth-second timebase shared by hold, start-up and auto-zero timers
    assign tick = (tick_cnt_reg == 32'(TENTH_CYCLES - 1));
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tick_cnt_reg <= 32'h0;
        end else begin
            tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
        end
    end

    assign shift_pulse = keys_in.shift && !prev_shift_reg;
    assign mode_pulse  = keys_in.mode && !prev_mode_reg;
    assign up_pulse    = keys_in.up && !prev_up_reg;
    assign hold_long   = tick && keys_in.level && !hold_done_reg &&
                         hold_reg == 5'(mms_pkg::HOLD_LONG_TENTHS - 1);
    assign hold_short  = tick && keys_in.level && !hold_done_reg &&
                         hold_reg == 5'(mms_pkg::HOLD_SHORT_TENTHS - 1);

    // A hold acts once per press; release re-arms it
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hold_reg       <= 5'h00;
            hold_done_reg  <= 1'b0;
            prev_shift_reg <= 1'b0;
            prev_mode_reg  <= 1'b0;
            prev_up_reg    <= 1'b0;
        end else begin
            prev_shift_reg <= keys_in.shift;
            prev_mode_reg  <= keys_in.mode;
            prev_up_reg    <= keys_in.up;
            if (!keys_in.level) begin
                hold_reg      <= 5'h00;
                hold_done_reg <= 1'b0;
            end else if (tick && !hold_done_reg) begin
                hold_reg <= hold_reg + 5'h01;
                if ((level_reg == mms_pkg::MMS_LVL_OPER) ? hold_long : hold_short) begin
                    hold_done_reg <= 1'b1;
                end
            end
        end
    end

    assign pass_ok  = pass_sign_in &&
                      (pass_mag_in == (TEMP_VARIANT ? mms_pkg::PASS_TEMP_MAG
                                                    : mms_pkg::PASS_PROC_MAG));
    assign edit_max = (param_reg == mms_pkg::PAR_MEAN)  ? 14'h0003 :
                      (param_reg == mms_pkg::PAR_AUTOZ) ? 14'(mms_pkg::AUTOZERO_MAX_TENTHS) :
                      (param_reg == mms_pkg::PAR_STARTUP) ? 14'(mms_pkg::STARTUP_MAX_TENTHS) :
                      14'(mms_pkg::HYST_MAX);
    assign cur_val  = (param_reg == mms_pkg::PAR_MEAN)  ? {12'h000, mean_sel_reg} :
                      (param_reg == mms_pkg::PAR_HYS1)  ? hyst1_reg :
                      (param_reg == mms_pkg::PAR_HYS2)  ? hyst2_reg :
                      (param_reg == mms_pkg::PAR_AUTOZ) ? {6'h00, az_reg} :
                      {4'h0, st_reg};

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            level_reg    <= mms_pkg::MMS_LVL_OPER;
            edit_reg     <= mms_pkg::MMS_ED_NAME;
            param_reg    <= mms_pkg::PAR_MEAN;
            edit_val_reg <= 14'h0000;
            mean_sel_reg <= mms_pkg::MEAN_RST;
            hyst1_reg    <= mms_pkg::HYST_RST;
            hyst2_reg    <= mms_pkg::HYST_RST;
            az_reg       <= mms_pkg::AUTOZERO_RST;
            st_reg       <= mms_pkg::STARTUP_RST;
        end else if (level_reg == mms_pkg::MMS_LVL_OPER && hold_long) begin
            level_reg <= mms_pkg::MMS_LVL_INIT;
            edit_reg  <= mms_pkg::MMS_ED_NAME;
        end else if (level_reg != mms_pkg::MMS_LVL_OPER && hold_short) begin
            level_reg <= (level_reg == mms_pkg::MMS_LVL_ADV) ? mms_pkg::MMS_LVL_INIT
                                                             : mms_pkg::MMS_LVL_OPER;
            edit_reg  <= mms_pkg::MMS_ED_NAME;
        end else if (level_reg == mms_pkg::MMS_LVL_INIT) begin
            if (mode_pulse && pass_ok) begin
                level_reg <= mms_pkg::MMS_LVL_ADV;
                param_reg <= mms_pkg::PAR_MEAN;
            end
        end else if (level_reg == mms_pkg::MMS_LVL_ADV) begin
            case (edit_reg)
                mms_pkg::MMS_ED_NAME: begin
                    if (shift_pulse) edit_reg <= mms_pkg::MMS_ED_VALUE;
                    else if (mode_pulse) param_reg <= (param_reg == mms_pkg::PAR_LAST)
                                                      ? mms_pkg::PAR_MEAN : param_reg + 3'h1;
                end
                mms_pkg::MMS_ED_VALUE: begin
                    if (shift_pulse) begin
                        edit_reg     <= mms_pkg::MMS_ED_EDIT;
                        edit_val_reg <= cur_val;
                    end else if (mode_pulse) begin
                        edit_reg  <= mms_pkg::MMS_ED_NAME;
                        param_reg <= (param_reg == mms_pkg::PAR_LAST)
                                     ? mms_pkg::PAR_MEAN : param_reg + 3'h1;
                    end
                end
                mms_pkg::MMS_ED_EDIT: begin
                    if (up_pulse) begin
                        edit_val_reg <= (edit_val_reg >= edit_max) ? 14'h0000
                                                                   : edit_val_reg + 14'h0001;
                    end else if (mode_pulse) begin
                        case (param_reg)
                            mms_pkg::PAR_MEAN:  mean_sel_reg <= edit_val_reg[1:0];
                            mms_pkg::PAR_HYS1:  hyst1_reg <= edit_val_reg;
                            mms_pkg::PAR_HYS2:  hyst2_reg <= edit_val_reg;
                            mms_pkg::PAR_AUTOZ: az_reg    <= edit_val_reg[7:0];
                            default:            st_reg    <= edit_val_reg[9:0];
                        endcase
                        edit_reg  <= mms_pkg::MMS_ED_NAME;
                        param_reg <= (param_reg == mms_pkg::PAR_LAST)
                                     ? mms_pkg::PAR_MEAN : param_reg + 3'h1;
                    end
                end
                default: edit_reg <= mms_pkg::MMS_ED_NAME;
            endcase
        end
    end

    // Start-up delay counted from reset release; outputs stay off meanwhile
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            start_cnt_reg <= 10'h000;
            measuring_reg <= 1'b0;
        end else if (!measuring_reg) begin
            if (start_cnt_reg >= st_reg) measuring_reg <= 1'b1;
            else if (tick) start_cnt_reg <= start_cnt_reg + 10'h001;
        end
    end

    // Auto-zero timer restarts on every pulse
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            az_cnt_reg  <= 8'h00;
            az_zero_reg <= 1'b0;
        end else if (pulse_in) begin
            az_cnt_reg  <= 8'h00;
            az_zero_reg <= 1'b0;
        end else if (az_cnt_reg >= az_reg) begin
            az_zero_reg <= 1'b1;
        end else if (tick) begin
            az_cnt_reg <= az_cnt_reg + 8'h01;
        end
    end

    // Moving-window history; sum2 and sum4 read the newest entries, sum8 reads all eight
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < 8; i++) hist_reg[i] <= '0;
        end else if (sample_valid_in && measuring_reg) begin
            hist_reg[0] <= sample_in;
            for (int i = 1; i < 8; i++) hist_reg[i] <= hist_reg[i-1];
        end
    end

    assign sum2 = (W+3)'(hist_reg[0]) + (W+3)'(hist_reg[1]);
    assign sum4 = sum2 + (W+3)'(hist_reg[2]) + (W+3)'(hist_reg[3]);
    assign sum8 = sum4 + (W+3)'(hist_reg[4]) + (W+3)'(hist_reg[5])
                + (W+3)'(hist_reg[6]) + (W+3)'(hist_reg[7]);
    assign mean_val = (mean_sel_reg == 2'h1) ? sum2[W:1] :
                      (mean_sel_reg == 2'h2) ? sum4[W+1:2] :
                      (mean_sel_reg == 2'h3) ? sum8[W+2:3] : hist_reg[0];

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            readout_reg <= '0;
        end else if (!measuring_reg || (freq_mode_in && az_zero_reg)) begin
            readout_reg <= '0;
        end else begin
            readout_reg <= mean_val;
        end
    end

    mms_compare #(.W(W)) u_cmp1 (
        .clk_sys_in  (clk_sys_in),
        .nrst_in     (nrst_in),
        .enable_in   (measuring_reg),
        .value_in    (readout_reg),
        .setpoint_in (setpoint1_in),
        .hyst_in     (hyst1_reg),
        .out_out     (comp1_out)
    );
    mms_compare #(.W(W)) u_cmp2 (
        .clk_sys_in  (clk_sys_in),
        .nrst_in     (nrst_in),
        .enable_in   (measuring_reg),
        .value_in    (readout_reg),
        .setpoint_in (setpoint2_in),
        .hyst_in     (hyst2_reg),
        .out_out     (comp2_out)
    );

    assign level_out              = level_reg;
    assign edit_state_out         = edit_reg;
    assign param_index_out        = param_reg;
    assign blink_out              = (edit_reg == mms_pkg::MMS_ED_EDIT);
    assign averaging_count_out    = mean_sel_reg;
    assign hyst1_out              = hyst1_reg;
    assign hyst2_out              = hyst2_reg;
    assign autozero_time_out      = az_reg;
    assign startup_delay_time_out = st_reg;
    assign measuring_out          = measuring_reg;
    assign readout_out            = readout_reg;
endmodule : mms_settings
